// ==== verilog/sldst_map.svh ====
// Constants for the short load/store and address-generation decoder
`ifndef SLDST_MAP_SVH
`define SLDST_MAP_SVH

`define SLDST_GRP_WB_TOP       3'h3
`define SLDST_GRP_HALF_TOP     4'h8
`define SLDST_GRP_SP_TOP       4'h9
`define SLDST_GRP_ADR_TOP      4'ha
`define SLDST_BIT_SIZE         12
`define SLDST_BIT_DIR          11
`define SLDST_SHORT_OFF_HI     10
`define SLDST_SHORT_OFF_LO     6
`define SLDST_BASE_HI          5
`define SLDST_BASE_LO          3
`define SLDST_SRCDST_HI        2
`define SLDST_SRCDST_LO        0
`define SLDST_LONG_DST_HI      10
`define SLDST_LONG_DST_LO      8
`define SLDST_WORD_OFF_HI      7
`define SLDST_WORD_OFF_LO      0
`define SLDST_WORD_SHIFT       2
`define SLDST_HALF_SHIFT       1
`define SLDST_PC_AHEAD         32'h0000_0004
`define SLDST_PC_CLR_MASK      32'hffff_fffd
`define SLDST_BYTE_MASK        32'h0000_00ff
`define SLDST_HALF_MASK        32'h0000_ffff
`define SLDST_BE_WORD          4'hf
`define SLDST_BE_HALF          4'h3
`define SLDST_BE_BYTE          4'h1
`define SLDST_ADR_CYCLES       2'h1
`define SLDST_STORE_CYCLES     2'h2
`define SLDST_LOAD_CYCLES      2'h3

`endif

// ==== verilog/sldst_pkg.sv ====
// Types for the short load/store and address-generation decoder
package sldst_pkg;

  typedef enum logic [2:0] {
    SLDST_OP_NONE,
    SLDST_OP_WORD,
    SLDST_OP_BYTE,
    SLDST_OP_HALF,
    SLDST_OP_STACK,
    SLDST_OP_ADDR
  } sldst_op_e;

  typedef enum logic [1:0] {
    SLDST_ST_IDLE,
    SLDST_ST_ACCESS,
    SLDST_ST_WRITEBACK
  } sldst_state_e;

endpackage : sldst_pkg

// ==== verilog/sldst_field_decode.sv ====
// Combinational field extraction for the four instruction groups
`timescale 1ns/100ps
`default_nettype none
`include "sldst_map.svh"

module sldst_field_decode (
  // Instruction
  input  wire logic [15:0]          i_instr,
  // Decoded fields
  output var  sldst_pkg::sldst_op_e o_op,
  output var  logic                 o_load,
  output var  logic                 o_use_sp,
  output var  logic [2:0]           o_base_reg_field,
  output var  logic [2:0]           o_dst_reg,
  output var  logic [31:0]          o_imm
);

  logic [4:0] short_offset_field;
  logic [7:0] word_offset_field;

  always_comb begin
    short_offset_field = i_instr[`SLDST_SHORT_OFF_HI:`SLDST_SHORT_OFF_LO]; // RQ1
    word_offset_field  = i_instr[`SLDST_WORD_OFF_HI:`SLDST_WORD_OFF_LO];   // RQ18
    o_op             = sldst_pkg::SLDST_OP_NONE;
    o_load           = i_instr[`SLDST_BIT_DIR];                          // RQ2 RQ11
    o_use_sp         = 1'b0;
    o_base_reg_field = i_instr[`SLDST_BASE_HI:`SLDST_BASE_LO];            // RQ1 RQ19
    o_dst_reg        = i_instr[`SLDST_SRCDST_HI:`SLDST_SRCDST_LO];        // RQ1 RQ19
    o_imm            = 32'h0;
    if (i_instr[15:13] == `SLDST_GRP_WB_TOP) begin
      if (i_instr[`SLDST_BIT_SIZE]) begin
        o_op  = sldst_pkg::SLDST_OP_BYTE;
        o_imm = {27'h0, short_offset_field};                             // RQ4
      end else begin
        o_op  = sldst_pkg::SLDST_OP_WORD;
        o_imm = {25'h0, short_offset_field, 2'h0};                       // RQ3
      end
    end else if (i_instr[15:12] == `SLDST_GRP_HALF_TOP) begin            // RQ18
      o_op  = sldst_pkg::SLDST_OP_HALF;
      o_imm = {26'h0, short_offset_field, 1'h0};                         // RQ10
    end else if (i_instr[15:12] == `SLDST_GRP_SP_TOP) begin              // RQ18
      o_op      = sldst_pkg::SLDST_OP_STACK;
      o_use_sp  = 1'b1;
      o_dst_reg = i_instr[`SLDST_LONG_DST_HI:`SLDST_LONG_DST_LO];
      o_imm     = {22'h0, word_offset_field, 2'h0};                      // RQ12
    end else if (i_instr[15:12] == `SLDST_GRP_ADR_TOP) begin             // RQ18
      o_op      = sldst_pkg::SLDST_OP_ADDR;
      o_use_sp  = i_instr[`SLDST_BIT_DIR];                               // RQ13
      o_load    = 1'b0;
      o_dst_reg = i_instr[`SLDST_LONG_DST_HI:`SLDST_LONG_DST_LO];
      o_imm     = {22'h0, word_offset_field, 2'h0};                      // RQ14
    end
  end

endmodule : sldst_field_decode
`default_nettype wire

// ==== verilog/sldst_decoder.sv ====
// Decode and execute unit for short load/store and address generation
`timescale 1ns/100ps
`default_nettype none
`include "sldst_map.svh"

// Functional notes
// RQ1: Offset bits 10:6, base 5:3, data 2:0
// RQ2: Bit 11 load, bit 12 byte; base plus immediate
// RQ3: Word offset scaled by four
// RQ4: Byte offset used unscaled
// RQ5: Word store writes register, load fills it
// RQ6: Byte store writes low eight bits only
// RQ7: Byte load places single byte in register
// RQ8: Half store writes low sixteen bits
// RQ9: Half load zeroes upper sixteen bits
// RQ10: Half offset scaled by two
// RQ11: Stack group: SP plus offset, bit 11 load
// RQ12: Stack offset eight bits times four
// RQ13: Address generation: PC or SP plus immediate
// RQ14: Address immediate is field times four
// RQ15: PC base is address plus four, bit1 cleared
// RQ16: Address generation leaves status flags alone
// RQ17: Cycle count matches full-width equivalent
// RQ18: Top opcodes 1000, 1001, 1010 select groups
// RQ19: Register fields address eight low registers
module sldst_decoder (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Instruction issue
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr,
  input  wire logic [31:0] i_instr_addr,
  output logic             o_instr_ready,
  // Register file read values
  input  wire logic [31:0] i_base_value,
  input  wire logic [31:0] i_data_value,
  input  wire logic [31:0] i_sp_value,
  output logic [2:0]       o_base_reg_field,
  output logic [2:0]       o_data_reg,
  // Memory access
  output logic             o_mem_req,
  output logic             o_mem_write,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  output logic [3:0]       o_mem_be,
  input  wire logic [31:0] i_mem_rdata,
  // Register write back
  output logic             o_wb_en,
  output logic [2:0]       o_wb_reg,
  output logic [31:0]      o_wb_data,
  output logic             o_flags_we,
  // Status
  output logic             o_done,
  output logic             o_unknown
);

  typedef struct packed {
    sldst_pkg::sldst_state_e state;
    sldst_pkg::sldst_op_e    op;
    logic                    load;
    logic [1:0]              cnt;
    logic                    ready;
    logic [2:0]              base_reg;
    logic [2:0]              data_reg;
    logic                    mem_req;
    logic                    mem_write;
    logic [31:0]             mem_addr;
    logic [31:0]             mem_wdata;
    logic [3:0]              mem_be;
    logic                    wb_en;
    logic [2:0]              wb_reg;
    logic [31:0]             wb_data;
    logic                    flags_we;
    logic                    done;
    logic                    unknown;
  } sldst_state_s;

  sldst_state_s         state_reg;
  sldst_state_s         state_next;
  sldst_pkg::sldst_op_e dec_op;
  logic                 dec_load;
  logic                 dec_use_sp;
  logic [2:0]           dec_base;
  logic [2:0]           dec_dst;
  logic [31:0]          dec_imm;

  default clocking sldst_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sldst_field_decode u_decode (
    .i_instr          (i_instr),
    .o_op             (dec_op),
    .o_load           (dec_load),
    .o_use_sp         (dec_use_sp),
    .o_base_reg_field (dec_base),
    .o_dst_reg        (dec_dst),
    .o_imm            (dec_imm)
  );

  // Program counter base as seen by address generation
  function automatic logic [31:0] pc_base(input logic [31:0] addr);
    pc_base = (addr + `SLDST_PC_AHEAD) & `SLDST_PC_CLR_MASK;             // RQ15
  endfunction : pc_base

  // Total cycles of each operation, equal to the full-width form
  function automatic logic [1:0] op_cycles(input sldst_pkg::sldst_op_e op,
                                           input logic ld);
    if (op == sldst_pkg::SLDST_OP_ADDR)
      op_cycles = `SLDST_ADR_CYCLES;
    else if (ld)
      op_cycles = `SLDST_LOAD_CYCLES;
    else
      op_cycles = `SLDST_STORE_CYCLES;
  endfunction : op_cycles

  always_comb begin
    state_next          = state_reg;
    state_next.mem_req  = 1'b0;
    state_next.wb_en    = 1'b0;
    state_next.done     = 1'b0;
    state_next.unknown  = 1'b0;
    state_next.flags_we = 1'b0;                                          // RQ16
    case (state_reg.state)
      sldst_pkg::SLDST_ST_IDLE: begin
        state_next.ready    = 1'b1;
        state_next.base_reg = dec_base;
        state_next.data_reg = dec_dst;
        if (i_instr_valid && state_reg.ready) begin
          state_next.op   = dec_op;
          state_next.load = dec_load;
          state_next.cnt  = op_cycles(dec_op, dec_load) - 2'h1;          // RQ17
          if (dec_op == sldst_pkg::SLDST_OP_NONE) begin
            state_next.unknown = 1'b1;
          end else if (dec_op == sldst_pkg::SLDST_OP_ADDR) begin
            // Single cycle result; status flags never written
            state_next.wb_en   = 1'b1;                                   // RQ13
            state_next.wb_reg  = dec_dst;
            state_next.wb_data = (dec_use_sp ? i_sp_value : pc_base(i_instr_addr))
                                 + dec_imm;                              // RQ13 RQ14
            state_next.done    = 1'b1;
          end else begin
            state_next.ready     = 1'b0;
            state_next.state     = sldst_pkg::SLDST_ST_ACCESS;
            state_next.mem_req   = 1'b1;
            state_next.mem_write = ~dec_load;                            // RQ2 RQ11
            state_next.mem_addr  = (dec_use_sp ? i_sp_value : i_base_value)
                                   + dec_imm;                            // RQ2 RQ11
            state_next.wb_reg    = dec_dst;
            case (dec_op)
              sldst_pkg::SLDST_OP_BYTE: begin
                state_next.mem_be    = `SLDST_BE_BYTE;
                state_next.mem_wdata = i_data_value & `SLDST_BYTE_MASK;  // RQ6
              end
              sldst_pkg::SLDST_OP_HALF: begin
                state_next.mem_be    = `SLDST_BE_HALF;
                state_next.mem_wdata = i_data_value & `SLDST_HALF_MASK;  // RQ8
              end
              default: begin
                state_next.mem_be    = `SLDST_BE_WORD;
                state_next.mem_wdata = i_data_value;                     // RQ5
              end
            endcase
          end
        end
      end
      sldst_pkg::SLDST_ST_ACCESS: begin
        state_next.cnt = state_reg.cnt - 2'h1;                           // RQ17
        if (state_reg.load) begin
          state_next.state = sldst_pkg::SLDST_ST_WRITEBACK;
          case (state_reg.op)
            sldst_pkg::SLDST_OP_BYTE:
              state_next.wb_data = i_mem_rdata & `SLDST_BYTE_MASK;       // RQ7
            sldst_pkg::SLDST_OP_HALF:
              state_next.wb_data = i_mem_rdata & `SLDST_HALF_MASK;       // RQ9
            default:
              state_next.wb_data = i_mem_rdata;                          // RQ5
          endcase
        end else begin
          state_next.state = sldst_pkg::SLDST_ST_IDLE;
          state_next.ready = 1'b1;
          state_next.done  = 1'b1;
        end
      end
      sldst_pkg::SLDST_ST_WRITEBACK: begin
        state_next.cnt   = state_reg.cnt - 2'h1;
        state_next.wb_en = 1'b1;                                         // RQ5
        state_next.done  = 1'b1;
        state_next.ready = 1'b1;
        state_next.state = sldst_pkg::SLDST_ST_IDLE;
      end
      default: begin
        state_next.state = sldst_pkg::SLDST_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_instr_ready    = state_reg.ready;
  assign o_base_reg_field = state_reg.base_reg;
  assign o_data_reg       = state_reg.data_reg;
  assign o_mem_req        = state_reg.mem_req;
  assign o_mem_write      = state_reg.mem_write;
  assign o_mem_addr       = state_reg.mem_addr;
  assign o_mem_wdata      = state_reg.mem_wdata;
  assign o_mem_be         = state_reg.mem_be;
  assign o_wb_en          = state_reg.wb_en;
  assign o_wb_reg         = state_reg.wb_reg;
  assign o_wb_data        = state_reg.wb_data;
  assign o_flags_we       = state_reg.flags_we;                          // RQ16
  assign o_done           = state_reg.done;
  assign o_unknown        = state_reg.unknown;

  // Issue bookkeeping seen by the checks
  logic take;
  assign take = i_instr_valid && o_instr_ready;

  word_scale_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ3
    take && i_instr[15:12] == 4'h6 |=> o_mem_addr == $past(i_base_value)
      + {25'h0, $past(i_instr[10:6]), 2'h0})
    else $error("word offset not scaled by four");

  byte_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ4
    take && i_instr[15:12] == 4'h7 |=> o_mem_addr == $past(i_base_value)
      + {27'h0, $past(i_instr[10:6])} && o_mem_be == 4'h1)
    else $error("byte offset wrong");

  byte_store_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ6
    o_mem_req && o_mem_write && o_mem_be == 4'h1 |-> o_mem_wdata[31:8] == 24'h0)
    else $error("byte store wider than a byte");

  half_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ10
    take && i_instr[15:12] == 4'h8 |=> o_mem_addr == $past(i_base_value)
      + {26'h0, $past(i_instr[10:6]), 1'h0} && o_mem_be == 4'h3)
    else $error("half offset not scaled by two");

  half_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ9
    take && i_instr[15:11] == 5'h11 |=> ##2 o_wb_en && o_wb_data[31:16] == 16'h0)
    else $error("half load upper bits not cleared");

  stack_addr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ12
    take && i_instr[15:12] == 4'h9 |=> o_mem_addr == $past(i_sp_value)
      + {22'h0, $past(i_instr[7:0]), 2'h0} && o_mem_write == !$past(i_instr[11]))
    else $error("stack address wrong");

  pc_addr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ15
    take && i_instr[15:11] == 5'h14 |=> o_wb_en && o_wb_data ==
      (($past(i_instr_addr) + 32'h4) & 32'hffff_fffd) + {22'h0, $past(i_instr[7:0]), 2'h0})
    else $error("pc relative address wrong");

  flags_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ16
    !o_flags_we)
    else $error("status flags written");

  load_cycles_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ17
    take && i_instr[15:13] == 3'h3 && i_instr[11] |=> !o_done [*2] ##1 o_done && o_wb_en)
    else $error("load cycle count wrong");

  store_cycles_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ17
    take && i_instr[15:12] == 4'h9 && !i_instr[11] |=> !o_done ##1 o_done && !o_wb_en)
    else $error("store cycle count wrong");

  cycle_count_a: assert property ( // RQ17
    o_done |-> state_reg.cnt == 2'h0)
    else $error("instruction ended before its cycle count");

  word_store_a: assert property ( // RQ5
    take && i_instr[15:11] == 5'h0c |=> o_mem_write && o_mem_wdata == $past(i_data_value))
    else $error("word store data wrong");

  word_load_a: assert property ( // RQ2 RQ5
    take && i_instr[15:11] == 5'h0d |=> o_mem_req && !o_mem_write && o_mem_be == 4'hf)
    else $error("word load request wrong");

  word_rdata_a: assert property ( // RQ5
    take && i_instr[15:11] == 5'h0d |=> ##2 o_wb_en && o_wb_data == $past(i_mem_rdata, 2))
    else $error("word load data wrong");

  byte_load_a: assert property ( // RQ7
    take && i_instr[15:11] == 5'h0f |=> ##2 o_wb_data == {24'h0, $past(i_mem_rdata[7:0], 2)})
    else $error("byte load data wrong");

  half_store_a: assert property ( // RQ8
    take && i_instr[15:11] == 5'h10 |=> o_mem_wdata == {16'h0, $past(i_data_value[15:0])})
    else $error("half store data wrong");

  half_data_a: assert property ( // RQ9
    take && i_instr[15:11] == 5'h11 |=> ##2 o_wb_data[15:0] == $past(i_mem_rdata[15:0], 2))
    else $error("half load low bits wrong");

  short_regs_a: assert property ( // RQ1 RQ19
    take && i_instr[15:13] == 3'h3 |=> o_wb_reg == $past(i_instr[2:0])
      && o_base_reg_field == $past(i_instr[5:3]))
    else $error("register fields wrong");

  stack_reg_a: assert property ( // RQ11 RQ18
    take && i_instr[15:12] == 4'h9 |=> o_wb_reg == $past(i_instr[10:8]) && o_mem_be == 4'hf)
    else $error("stack register or lanes wrong");

  stack_data_a: assert property ( // RQ11
    take && i_instr[15:11] == 5'h12 |=> o_mem_write && o_mem_wdata == $past(i_data_value))
    else $error("stack store data wrong");

  sp_addr_a: assert property ( // RQ13 RQ14
    take && i_instr[15:11] == 5'h15 |=> o_wb_en
      && o_wb_data == $past(i_sp_value) + {22'h0, $past(i_instr[7:0]), 2'h0})
    else $error("stack based address wrong");

  addr_reg_a: assert property ( // RQ13 RQ17
    take && i_instr[15:12] == 4'ha |=> o_wb_reg == $past(i_instr[10:8])
      && o_done && !o_mem_req)
    else $error("address result register wrong");

  unknown_op_a: assert property ( // RQ18
    take && i_instr[15:14] == 2'h3 |=> o_unknown && !o_mem_req && !o_wb_en)
    else $error("foreign instruction not dropped");

  busy_ready_a: assert property ( // RQ17
    o_mem_req |-> !o_instr_ready)
    else $error("ready during memory access");

  req_pulse_a: assert property ( // RQ17
    o_mem_req |=> !o_mem_req)
    else $error("memory request longer than a cycle");

  done_ready_a: assert property ( // RQ17
    o_done |-> o_instr_ready)
    else $error("done without ready");

  wb_done_a: assert property ( // RQ5 RQ13
    o_wb_en |-> o_done)
    else $error("write back outside instruction end");

  cov_word_load_c:  cover property (@(posedge i_clock) take && i_instr[15:11] == 5'h0d);
  cov_byte_store_c: cover property (@(posedge i_clock) take && i_instr[15:11] == 5'h0e);
  cov_stack_c:      cover property (@(posedge i_clock) take && i_instr[15:12] == 4'h9);
  cov_addr_sp_c:    cover property (@(posedge i_clock) take && i_instr[15:11] == 5'h15);
  cov_half_load_c:  cover property (@(posedge i_clock) take && i_instr[15:11] == 5'h11);

endmodule : sldst_decoder
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the short load/store and address-generation decoder
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        i_clock;
  logic        i_rst_n;
  logic        i_instr_valid;
  logic [15:0] i_instr;
  logic [31:0] i_instr_addr;
  logic        o_instr_ready;
  logic [31:0] i_base_value;
  logic [31:0] i_data_value;
  logic [31:0] i_sp_value;
  logic [2:0]  o_base_reg_field;
  logic [2:0]  o_data_reg;
  logic        o_mem_req;
  logic        o_mem_write;
  logic [31:0] o_mem_addr;
  logic [31:0] o_mem_wdata;
  logic [3:0]  o_mem_be;
  logic [31:0] i_mem_rdata;
  logic        o_wb_en;
  logic [2:0]  o_wb_reg;
  logic [31:0] o_wb_data;
  logic        o_flags_we;
  logic        o_done;
  logic        o_unknown;
  int          n_errors;
  int          checks_done;

  localparam logic [31:0] SP_VAL = 32'h2000_0ff0;

  // Register file model: upper bits set so masking is visible
  function automatic logic [31:0] reg_val(input logic [2:0] idx);
    return 32'hfedc_ba00 | {24'h0, 1'b0, idx, 4'h7};
  endfunction : reg_val

  assign i_base_value = reg_val(i_instr[5:3]);
  assign i_data_value = reg_val((i_instr[15:12] == 4'h9) ? i_instr[10:8] : i_instr[2:0]);
  assign i_sp_value   = SP_VAL;

  sldst_decoder i_sldst_decoder (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_instr_addr(i_instr_addr), .o_instr_ready(o_instr_ready),
    .i_base_value(i_base_value), .i_data_value(i_data_value), .i_sp_value(i_sp_value),
    .o_base_reg_field(o_base_reg_field), .o_data_reg(o_data_reg), .o_mem_req(o_mem_req),
    .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_mem_be(o_mem_be), .i_mem_rdata(i_mem_rdata), .o_wb_en(o_wb_en),
    .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data), .o_flags_we(o_flags_we),
    .o_done(o_done), .o_unknown(o_unknown)
  );

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic close_out;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step;
    @(posedge i_clock);
    #1;
  endtask : step

  task automatic wait_ready;
    int k;
    for (k = 0; k < 20 && o_instr_ready !== 1'b1; k++) begin
      step();
    end
    if (o_instr_ready !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask : wait_ready

  // Issue one load or store and follow it cycle by cycle
  task automatic mem_op(input logic [15:0] ins, input logic ld, input logic [31:0] adr,
                        input logic [3:0] be, input logic [31:0] dat,
                        input logic [31:0] rd, input logic [2:0] wr);
    wait_ready();
    i_instr = ins;
    i_instr_valid = 1'b1;
    step();
    i_instr_valid = 1'b0;
    chk(o_mem_req, 1'b1);
    chk(o_mem_write, !ld);
    chk(o_mem_addr, adr);
    chk(o_mem_be, be);
    chk(o_instr_ready, 1'b0);
    chk(o_base_reg_field, ins[5:3]);
    chk(o_data_reg, (ins[15:12] == 4'h9) ? ins[10:8] : ins[2:0]);
    if (!ld) chk(o_mem_wdata, dat);
    i_mem_rdata = rd;
    step();
    i_mem_rdata = ~rd;
    chk(o_mem_req, 1'b0);
    chk(o_done, !ld);
    if (ld) begin
      step();
      chk(o_wb_en, 1'b1);
      chk(o_wb_reg, wr);
      chk(o_wb_data, dat);
      chk(o_done, 1'b1);
    end
  endtask : mem_op

  task automatic word_ops;
    mem_op({5'b01100, 5'd31, 3'd5, 3'd2}, 1'b0, reg_val(3'd5) + 32'd124, 4'hf,
           reg_val(3'd2), 32'h0, 3'd0);
    mem_op({5'b01101, 5'd29, 3'd5, 3'd2}, 1'b1, reg_val(3'd5) + 32'd116, 4'hf,
           32'h1357_9bdf, 32'h1357_9bdf, 3'd2);
  endtask : word_ops

  task automatic byte_ops;
    mem_op({5'b01110, 5'd13, 3'd0, 3'd1}, 1'b0, reg_val(3'd0) + 32'd13, 4'h1,
           reg_val(3'd1) & 32'h0000_00ff, 32'h0, 3'd0);
    mem_op({5'b01111, 5'd31, 3'd7, 3'd3}, 1'b1, reg_val(3'd7) + 32'd31, 4'h1,
           32'h0000_00a5, 32'h5a5a_c3a5, 3'd3);
  endtask : byte_ops

  task automatic half_ops;
    mem_op({5'b10000, 5'd28, 3'd1, 3'd6}, 1'b0, reg_val(3'd1) + 32'd56, 4'h3,
           reg_val(3'd6) & 32'h0000_ffff, 32'h0, 3'd0);
    mem_op({5'b10001, 5'd2, 3'd7, 3'd4}, 1'b1, reg_val(3'd7) + 32'd4, 4'h3,
           32'h0000_8001, 32'hffff_8001, 3'd4);
  endtask : half_ops

  task automatic stack_ops;
    mem_op({5'b10010, 3'd4, 8'd123}, 1'b0, SP_VAL + 32'd492, 4'hf,
           reg_val(3'd4), 32'h0, 3'd0);
    mem_op({5'b10011, 3'd3, 8'd255}, 1'b1, SP_VAL + 32'd1020, 4'hf,
           32'h2468_ace0, 32'h2468_ace0, 3'd3);
  endtask : stack_ops

  // Program-counter and stack-pointer forms issued back to back
  task automatic addr_gen;
    wait_ready();
    i_instr_addr = 32'h0000_2002;
    i_instr = {5'b10100, 3'd2, 8'd143};
    i_instr_valid = 1'b1;
    step();
    chk(o_wb_en, 1'b1);
    chk(o_wb_reg, 3'd2);
    chk(o_wb_data, 32'h0000_2240);
    chk(o_flags_we, 1'b0);
    i_instr = {5'b10101, 3'd6, 8'd53};
    step();
    i_instr_valid = 1'b0;
    chk(o_wb_en, 1'b1);
    chk(o_wb_reg, 3'd6);
    chk(o_wb_data, SP_VAL + 32'd212);
    chk(o_flags_we, 1'b0);
  endtask : addr_gen

  task automatic foreign_op;
    wait_ready();
    i_instr = 16'he000;
    i_instr_valid = 1'b1;
    step();
    i_instr_valid = 1'b0;
    chk(o_unknown, 1'b1);
    chk(o_mem_req, 1'b0);
    chk(o_wb_en, 1'b0);
  endtask : foreign_op

  initial begin
    n_errors = 0;
    checks_done = 0;
    i_rst_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 16'h0;
    i_instr_addr = 32'h0;
    i_mem_rdata = 32'h0;
    repeat (6) step();
    chk(o_instr_ready, 1'b0);
    i_rst_n = 1'b1;
    word_ops();
    byte_ops();
    half_ops();
    stack_ops();
    addr_gen();
    foreign_op();
    step();
    close_out();
  end
endmodule : tb

`default_nettype wire
